//--- tb/mcd_dev_model.sv
// Far-side device model: takes command codes from the link, keeps its own
// command counter. Assumes the host holds cmd_valid and cmd_code until taken.
`timescale 1ns/1ns
module mcd_dev_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [10:0] cmd_code,
  input wire logic cmd_valid,
  input wire logic slow,
  input wire logic ok_in,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_data_ok,
  output logic [7:0] count,
  output logic [10:0] last_code
);
  logic pend;
  logic [2:0] dly;
  int seed = 4;

  // Ready, stalls at random when slow
  always_ff @(posedge clk)
    cmd_ready <= reset ? 1'b0 : (slow ? 1'($random(seed)) : 1'b1);

  // Take, classify and count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count <= 8'h00;
      last_code <= 11'h000;
      pend <= 1'b0;
      dly <= 3'h0;
      cmd_done <= 1'b0;
      cmd_data_ok <= 1'b0;
    end
    else
    begin
      cmd_done <= 1'b0;
      cmd_data_ok <= (pend && dly == 3'h4) ? ok_in : ~cmd_data_ok;
      if (pend)
      begin
        dly <= dly + 3'h1;
        if (dly == 3'h4)
        begin
          pend <= 1'b0;
          cmd_done <= 1'b1;
          count <= count + 8'(ok_in);
        end
      end
      if (cmd_valid && cmd_ready)
      begin
        last_code <= cmd_code;
        casez (cmd_code)
          11'h040, 11'h041, 11'h711, 11'h712, 11'h714, 11'h716, 11'h718, 11'h71C,
          11'h71D, 11'h71E, 11'h71F, 11'h723, 11'h028, 11'h029, 11'h02D, 11'h02F,
          11'h038, 11'b01??11?0???, 11'b001?11?10??, 11'b10???01????, 11'b1000000????:
            count <= count + 8'h01;
          11'h020, 11'h021, 11'h058, 11'h05A, 11'h05C, 11'h05E, 11'h717, 11'h715,
          11'h721, 11'h039:
          begin
            pend <= 1'b1;
            dly <= 3'h0;
          end
          11'h02E, 11'h027: count <= 8'h00;
          default: ;
        endcase
      end
    end
  end
endmodule

//--- tb/test_mcd_host.sv
// Testbench of the host command controller: directed and random commands
// over AHB-Lite, with the device model on the link side.
`timescale 1ns/1ns
module test_mcd_host;
  import mcd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic ok_in = 1'b0;
  logic hready, hreadyout, hresp, cmd_valid, cmd_ready, cmd_done, cmd_data_ok;
  logic [31:0] hrdata;
  logic [10:0] cmd_code, dev_last, last;
  logic [7:0] dev_count, exp_cnt;
  logic lp, refd;
  int mismatches = 0;
  int checks = 0;
  int seed = 4;
  localparam logic [10:0] TBL [0:44] = '{11'h033, 11'h034, 11'h035, 11'h020, 11'h022,
    11'h021, 11'h023, 11'h040, 11'h041, 11'h043, 11'h058, 11'h059, 11'h05A, 11'h05B,
    11'h05C, 11'h05D, 11'h05E, 11'h05F, 11'h000, 11'h000, 11'h000, 11'h000, 11'h711,
    11'h714, 11'h712, 11'h716, 11'h717, 11'h715, 11'h718, 11'h71C, 11'h71D, 11'h71E,
    11'h71F, 11'h721, 11'h722, 11'h723, 11'h028, 11'h029, 11'h02C, 11'h02E, 11'h02D,
    11'h02F, 11'h027, 11'h038, 11'h039};

  assign hready = hreadyout;
  always #20 clk = ~clk;

  mcd_host #(.CNT_W(8)) mcd_host_inst (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_data_ok(cmd_data_ok));
  mcd_dev_model mcd_dev_model_inst (.clk(clk), .reset(reset), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid), .slow(slow), .ok_in(ok_in), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_data_ok(cmd_data_ok), .count(dev_count),
    .last_code(dev_last));

  // Code expected for a command word
  function automatic logic [10:0] exp_code(input logic [31:0] w);
    case (w[5:0])
      6'd18: return {2'b01, w[9], w[6], 2'b11, w[7], 1'b0, w[8], w[11:10]};
      6'd19: return {3'b001, w[6], 2'b11, w[7], 2'b10, w[11:10]};
      6'd20: return {2'b10, w[12], w[13], w[18], 2'b01, w[17:14]};
      6'd21: return {7'h40, w[17:14]};
      default: return TBL[w[5:0]];
    endcase
  endfunction

  // Counter class: 1 always, 2 on good data, 3 zeroes, 0 none
  function automatic int inc_of(input logic [5:0] s);
    if (s inside {7, 8, [18:25], [28:32], 35, 36, 37, 40, 41, 43})
      return 1;
    if (s inside {3, 5, 10, 12, 14, 16, 26, 27, 33, 44})
      return 2;
    if (s inside {39, 42})
      return 3;
    return 0;
  endfunction

  task automatic end_of_test;
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Load, issue and judge one command
  task automatic run(input logic [31:0] w, input logic dbl);
    logic [31:0] rd;
    int n;
    n = 0;
    bus(1'b1, OFS_CMD, w, rd);
    bus(1'b0, OFS_CMD, 32'h0, rd);
    check(rd, w);
    bus(1'b1, OFS_GO, w, rd);
    if (dbl)
      bus(1'b1, OFS_GO, w, rd);
    do bus(1'b0, OFS_STATUS, 32'h0, rd); while (rd[0] !== 1'b0 && ++n < 60);
    if (w[5:0] > 6'd44 || (w[5:0] == 6'd9 && !lp))
      refd = 1'b1;
    else
    begin
      last = exp_code(w);
      case (inc_of(w[5:0]))
        1: exp_cnt = exp_cnt + 8'h01;
        2: exp_cnt = exp_cnt + 8'(ok_in);
        3: exp_cnt = 8'h00;
        default: ;
      endcase
      lp = (w[5:0] == 6'd8) ? 1'b1 : ((w[5:0] == 6'd7 || w[5:0] == 6'd42) ? 1'b0 : lp);
      check({21'h0, dev_last}, {21'h0, last});
    end
    check(rd & 32'h7FF7, {17'h0, last, 1'b0, lp, refd, 1'b0});
    bus(1'b0, OFS_COUNT, 32'h0, rd);
    check(rd, {24'h0, exp_cnt});
    check({24'h0, dev_count}, {24'h0, exp_cnt});
    if (refd)
      bus(1'b1, OFS_STATUS, 32'h2, rd);
    refd = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] rd, r;
    exp_cnt = 8'h00;
    lp = 1'b0;
    refd = 1'b0;
    last = 11'h000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    check(rd, RDATA_RESET);
    bus(1'b0, OFS_COUNT, 32'h0, rd);
    check(rd, RDATA_RESET);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    for (int s = 0; s < 46; s++)
    begin
      r = $random(seed);
      ok_in <= r[31];
      run({13'h0, r[18:6], 6'(s)}, 1'b0);
    end
    run(32'h9, 1'b0);
    ok_in <= 1'b1;
    slow <= 1'b1;
    run(32'h3, 1'b1);
    for (int i = 0; i < 80; i++)
    begin
      r = $random(seed);
      slow <= r[31];
      ok_in <= r[30];
      run({13'h0, r[18:0]}, 1'b0);
    end
    end_of_test();
  end

  // Watchdog
  initial
  begin
    #800000;
    mismatches++;
    end_of_test();
  end
endmodule

//--- verilog/mcd_code_enc.sv
// Command code builder: turns a command selection and its option
// fields into the eleven-bit code and the counter class of the command.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ns
module mcd_code_enc
  import mcd_pkg::*;
(
  input wire mcd_pkg::mcd_sel_t sel,
  input wire logic continuous_flag,
  input wire logic discharge_permit_flag,
  input wire logic filter_reset_flag,
  input wire logic red,
  input wire logic [1:0] ow,
  input wire logic aow,
  input wire logic pull_up_select,
  input wire logic [4:0] ch,
  output logic [10:0] code,
  output mcd_pkg::mcd_inc_t inc,
  output logic known
);
  import mcd_pkg::*;

  // Code lookup and counter class per selection
  always_comb
  begin
    code = CODE_RESET;
    inc = MCD_INC_NONE;
    known = 1'b1;
    case (sel)
      MCD_READ_STATUS_GROUP_D: code = CC_RD_STAT_D;
      MCD_READ_STATUS_GROUP_E: code = CC_RD_STAT_E;
      MCD_READ_ALL_AUX_AND_STATUS: code = CC_RD_ALL_AS;
      MCD_WRITE_BALANCE_PWM_A: begin code = CC_WR_PWM_A; inc = MCD_INC_COND; end
      MCD_READ_BALANCE_PWM_A: code = CC_RD_PWM_A;
      MCD_WRITE_BALANCE_PWM_B: begin code = CC_WR_PWM_B; inc = MCD_INC_COND; end
      MCD_READ_BALANCE_PWM_B: code = CC_RD_PWM_B;
      MCD_LOW_POWER_MONITOR_DISABLE: begin code = CC_LP_DIS; inc = MCD_INC_ALWAYS; end
      MCD_LOW_POWER_MONITOR_ENABLE: begin code = CC_LP_EN; inc = MCD_INC_ALWAYS; end
      MCD_LOW_POWER_HEARTBEAT: code = CC_LP_HB;
      MCD_WRITE_LOW_POWER_CONFIG: begin code = CC_LP_WR_CFG; inc = MCD_INC_COND; end
      MCD_READ_LOW_POWER_CONFIG: code = CC_LP_RD_CFG;
      MCD_WRITE_LOW_POWER_CELL_THRESHOLD: begin code = CC_LP_WR_CELL; inc = MCD_INC_COND; end
      MCD_READ_LOW_POWER_CELL_THRESHOLD: code = CC_LP_RD_CELL;
      MCD_WRITE_LOW_POWER_PIN_THRESHOLD: begin code = CC_LP_WR_PIN; inc = MCD_INC_COND; end
      MCD_READ_LOW_POWER_PIN_THRESHOLD: code = CC_LP_RD_PIN;
      MCD_CLEAR_LOW_POWER_FLAGS: begin code = CC_LP_CLR_FLAG; inc = MCD_INC_COND; end
      MCD_READ_LOW_POWER_FLAGS: code = CC_LP_RD_FLAG;
      // Conversion starts carry their option fields
      MCD_START_CELL_CONVERSION:
      begin
        code = {2'b01, red, continuous_flag, 2'b11, discharge_permit_flag, 1'b0, filter_reset_flag, ow};
        inc = MCD_INC_ALWAYS;
      end
      MCD_START_S_CONVERSION:
      begin
        code = {3'b001, continuous_flag, 2'b11, discharge_permit_flag, 2'b10, ow};
        inc = MCD_INC_ALWAYS;
      end
      MCD_START_AUX_CONVERSION:
      begin
        code = {2'b10, aow, pull_up_select, ch[4], 2'b01, ch[3:0]};
        inc = MCD_INC_ALWAYS;
      end
      MCD_START_SECOND_AUX_CONVERSION:
      begin
        code = {2'b10, 5'b00000, ch[3:0]};
        inc = MCD_INC_ALWAYS;
      end
      MCD_CLEAR_CELL_RESULTS: begin code = CC_CLR_CELL; inc = MCD_INC_ALWAYS; end
      MCD_CLEAR_FILTERED_RESULTS: begin code = CC_CLR_FILT; inc = MCD_INC_ALWAYS; end
      MCD_CLEAR_AUX_RESULTS: begin code = CC_CLR_AUX; inc = MCD_INC_ALWAYS; end
      MCD_CLEAR_S_CHANNEL_RESULTS: begin code = CC_CLR_S; inc = MCD_INC_ALWAYS; end
      MCD_CLEAR_FAULT_FLAGS: begin code = CC_CLR_FLAG; inc = MCD_INC_COND; end
      MCD_CLEAR_OVER_UNDER_VOLTAGE: begin code = CC_CLR_OVUV; inc = MCD_INC_COND; end
      MCD_POLL_ANY_CONVERTER: begin code = CC_POLL_ANY; inc = MCD_INC_ALWAYS; end
      MCD_POLL_CELL_CONVERTER: begin code = CC_POLL_CELL; inc = MCD_INC_ALWAYS; end
      MCD_POLL_S_CONVERTER: begin code = CC_POLL_S; inc = MCD_INC_ALWAYS; end
      MCD_POLL_AUX_CONVERTER: begin code = CC_POLL_AUX; inc = MCD_INC_ALWAYS; end
      MCD_POLL_SECOND_AUX_CONVERTER: begin code = CC_POLL_AUX2; inc = MCD_INC_ALWAYS; end
      MCD_WRITE_MASTER_PORT_GROUP: begin code = CC_WR_MPORT; inc = MCD_INC_COND; end
      MCD_READ_MASTER_PORT_GROUP: code = CC_RD_MPORT;
      MCD_START_MASTER_TRANSFER: begin code = CC_ST_MPORT; inc = MCD_INC_ALWAYS; end
      MCD_DISCHARGE_HALT: begin code = CC_DIS_HALT; inc = MCD_INC_ALWAYS; end
      MCD_DISCHARGE_RESUME: begin code = CC_DIS_RESUME; inc = MCD_INC_ALWAYS; end
      MCD_READ_SERIAL_IDENTITY: code = CC_RD_SID;
      MCD_RESET_COMMAND_COUNTER: code = CC_RST_CNT;
      MCD_SNAPSHOT_TAKE: begin code = CC_SNAP; inc = MCD_INC_ALWAYS; end
      MCD_SNAPSHOT_RELEASE: begin code = CC_UNSNAP; inc = MCD_INC_ALWAYS; end
      MCD_SOFT_RESTART: code = CC_SOFT_RST;
      MCD_UNLOCK_RETENTION: begin code = CC_UNLOCK_RR; inc = MCD_INC_ALWAYS; end
      MCD_WRITE_RETENTION: begin code = CC_WRITE_RR; inc = MCD_INC_COND; end
      default: known = 1'b0;
    endcase
  end

endmodule

//--- verilog/mcd_host.sv
// Host-side command controller for a stacked cell monitor. Software
// picks a command and its options over AHB-Lite; the block builds the
// eleven-bit code, hands it to the serial link and mirrors the device's
// command counter. Assumes a single AHB-Lite master and a link layer that
// frames the code, adds the check word and reports completion.
//
// How it works
// (R1) Status D/E and read-all codes
// (R2) Balance PWM group A/B write, read
// (R3) Low-power monitoring command codes
// (R4) Cell conversion code with option fields
// (R5) S conversion code with option fields
// (R6) Aux conversion code with channel, pull-up
// (R7) Second aux code: four-bit channel only
// (R8) Clear and poll command codes
// (R9) Master port write, read, start codes
// (R10) Mute, identity, counter, snapshot, retention codes
// (R11) Counter increments on action commands
// (R12) Reads, heartbeat, counter reset: no increment
// (R13) Write commands count only with valid data
// (R14) Heartbeat only while low-power mode active
// (R15) Continuous flag: single or continuous measurement
// (R16) Open-wire select picks even, odd, all
// (R17) Undefined codes are ignored
`timescale 1ns/1ns
module mcd_host
  import mcd_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [10:0] cmd_code,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic cmd_data_ok
);
  import mcd_pkg::*;

  typedef enum logic [1:0] {
    MCD_ST_IDLE = 2'b00,
    MCD_ST_SEND = 2'b01,
    MCD_ST_WAIT = 2'b11
  } mcd_state_t;

  mcd_state_t state;
  logic [CMD_W-1:0] cmd_reg;
  logic refused;
  logic lp_active;
  logic [CNT_W-1:0] exp_count;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic go;
  logic clr_refused;
  logic refuse_now;
  logic accept_now;
  logic [10:0] enc_code;
  mcd_inc_t enc_inc;
  logic enc_known;
  mcd_sel_t sent_sel;
  mcd_inc_t sent_inc;
  logic [CMD_W-1:0] sent_opt;
  mcd_sel_t cur_sel;

  // Read data for one register offset
  function automatic logic [31:0] read_mux(input logic [7:0] ofs, input logic [CMD_W-1:0] c,
                                           input logic busy, input logic rf, input logic lp,
                                           input logic [10:0] last, input logic [CNT_W-1:0] n);
    logic [31:0] r;
    r = RDATA_RESET;
    case (ofs)
      OFS_CMD: r[CMD_W-1:0] = c;
      OFS_STATUS:
      begin
        r[F_BUSY] = busy;
        r[F_REFUSED] = rf;
        r[F_LP_ACTIVE] = lp;
        r[F_LAST +: 11] = last;
      end
      OFS_COUNT: r[CNT_W-1:0] = n;
      default: r = RDATA_RESET;
    endcase
    return r;
  endfunction

  assign cur_sel = mcd_sel_t'(cmd_reg[F_SEL +: 6]);

  // Code builder for the currently selected command
  mcd_code_enc u_enc (
    .sel(cur_sel),
    .continuous_flag(cmd_reg[F_CONTINUOUS_FLAG]),
    .discharge_permit_flag(cmd_reg[F_DCP]),
    .filter_reset_flag(cmd_reg[F_FILTER_RESET_FLAG]),
    .red(cmd_reg[F_RED]),
    .ow(cmd_reg[F_OW +: 2]),
    .aow(cmd_reg[F_AOW]),
    .pull_up_select(cmd_reg[F_PUP]),
    .ch(cmd_reg[F_CH +: 5]),
    .code(enc_code),
    .inc(enc_inc),
    .known(enc_known)
  );

  // Bus address phase capture and registered read data
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= RDATA_RESET;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
        hrdata <= read_mux(haddr[7:0], cmd_reg, state != MCD_ST_IDLE, refused,
                           lp_active, cmd_code, exp_count);
    end
  end

  // Write strobes decoded in the data phase
  assign go = wr_pend && (wr_addr == OFS_GO);
  assign clr_refused = wr_pend && (wr_addr == OFS_STATUS) && hwdata[F_REFUSED];

  // Command register
  always_ff @(posedge clk)
  begin
    if (reset)
      cmd_reg <= CMD_RESET;
    else if (wr_pend && wr_addr == OFS_CMD)
      cmd_reg <= hwdata[CMD_W-1:0];
  end

  // Refuse unknown selections and heartbeat outside low-power mode
  // (R17) undefined never sent
  // (R14) heartbeat needs mode
  assign refuse_now = go && state == MCD_ST_IDLE &&
                      (!enc_known || (cur_sel == MCD_LOW_POWER_HEARTBEAT && !lp_active));
  assign accept_now = go && state == MCD_ST_IDLE && !refuse_now;

  // Sticky refusal flag, a new refusal wins over the clear
  always_ff @(posedge clk)
  begin
    if (reset)
      refused <= 1'b0;
    else if (refuse_now)
      refused <= 1'b1;
    else if (clr_refused)
      refused <= 1'b0;
  end

  // Command hand-off to the link and sequencing
  // (R1) (R2) (R3) (R8) (R9) (R10) fixed codes
  // (R4) (R5) (R6) (R7) (R15) (R16) option fields
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= MCD_ST_IDLE;
      cmd_code <= CODE_RESET;
      cmd_valid <= 1'b0;
      sent_sel <= MCD_READ_STATUS_GROUP_D;
      sent_inc <= MCD_INC_NONE;
      sent_opt <= CMD_RESET;
    end
    else
    begin
      case (state)
        MCD_ST_IDLE:
          if (accept_now)
          begin
            cmd_code <= enc_code;
            cmd_valid <= 1'b1;
            sent_sel <= cur_sel;
            sent_inc <= enc_inc;
            sent_opt <= cmd_reg;
            state <= MCD_ST_SEND;
          end
        MCD_ST_SEND:
          if (cmd_ready)
          begin
            cmd_valid <= 1'b0;
            state <= (sent_inc == MCD_INC_COND) ? MCD_ST_WAIT : MCD_ST_IDLE;
          end
        MCD_ST_WAIT:
          if (cmd_done)
            state <= MCD_ST_IDLE;
        default:
        begin
          state <= MCD_ST_IDLE;
          cmd_valid <= 1'b0;
        end
      endcase
    end
  end

  // Mirror of the device command counter
  // (R11) action commands count
  // (R12) reads and counter reset do not
  // (R13) writes count on valid data
  always_ff @(posedge clk)
  begin
    if (reset)
      exp_count <= '0;
    else if (state == MCD_ST_SEND && cmd_ready)
    begin
      if (sent_sel == MCD_RESET_COMMAND_COUNTER || sent_sel == MCD_SOFT_RESTART)
        exp_count <= '0;
      else if (sent_inc == MCD_INC_ALWAYS)
        exp_count <= exp_count + 1'b1;
    end
    else if (state == MCD_ST_WAIT && cmd_done && cmd_data_ok)
      exp_count <= exp_count + 1'b1;
  end

  // Low-power monitoring mode as last commanded
  always_ff @(posedge clk)
  begin
    if (reset)
      lp_active <= 1'b0;
    else if (state == MCD_ST_SEND && cmd_ready)
    begin
      if (sent_sel == MCD_LOW_POWER_MONITOR_ENABLE)
        lp_active <= 1'b1;
      else if (sent_sel == MCD_LOW_POWER_MONITOR_DISABLE || sent_sel == MCD_SOFT_RESTART)
        lp_active <= 1'b0;
    end
  end

  // Checks on the issued codes, the hand-off, heartbeat refusal and the counter mirror
  AST_STATUS_CODES: assert property (@(posedge clk) disable iff (reset) // (R1)
    $rose(cmd_valid) && sent_sel == MCD_READ_ALL_AUX_AND_STATUS |-> cmd_code == 11'h035)
    else $error("read-all code wrong");

  AST_PWM_CODES: assert property (@(posedge clk) disable iff (reset) // (R2)
    $rose(cmd_valid) && sent_sel == MCD_READ_BALANCE_PWM_B |-> cmd_code == 11'h023)
    else $error("pwm read B code wrong");

  AST_LP_CODES: assert property (@(posedge clk) disable iff (reset) // (R3)
    $rose(cmd_valid) && sent_sel == MCD_CLEAR_LOW_POWER_FLAGS |-> cmd_code == 11'h05E)
    else $error("low-power flag clear code wrong");

  AST_CELL_START: assert property (@(posedge clk) disable iff (reset) // (R4)
    $rose(cmd_valid) && sent_sel == MCD_START_CELL_CONVERSION |->
    cmd_code[10:9] == 2'b01 && cmd_code[6:5] == 2'b11 && !cmd_code[3] &&
    cmd_code[8] == sent_opt[F_RED] && cmd_code[1:0] == sent_opt[F_OW +: 2] &&
    cmd_code[7] == sent_opt[F_CONTINUOUS_FLAG])
    else $error("cell start code wrong");

  AST_S_START: assert property (@(posedge clk) disable iff (reset) // (R5)
    $rose(cmd_valid) && sent_sel == MCD_START_S_CONVERSION |->
    cmd_code[10:8] == 3'b001 && cmd_code[3:2] == 2'b10 && cmd_code[4] == sent_opt[F_DCP])
    else $error("s start code wrong");

  AST_AUX_START: assert property (@(posedge clk) disable iff (reset) // (R6)
    $rose(cmd_valid) && sent_sel == MCD_START_AUX_CONVERSION |->
    cmd_code[10:9] == 2'b10 && cmd_code[5:4] == 2'b01 &&
    {cmd_code[6], cmd_code[3:0]} == sent_opt[F_CH +: 5])
    else $error("aux start code wrong");

  AST_AUX2_START: assert property (@(posedge clk) disable iff (reset) // (R7)
    $rose(cmd_valid) && sent_sel == MCD_START_SECOND_AUX_CONVERSION |->
    cmd_code[10:4] == 7'h40)
    else $error("second aux start code wrong");

  AST_POLL_CODE: assert property (@(posedge clk) disable iff (reset) // (R8)
    $rose(cmd_valid) && sent_sel == MCD_POLL_AUX_CONVERTER |-> cmd_code == 11'h71E)
    else $error("aux poll code wrong");

  AST_MPORT_CODE: assert property (@(posedge clk) disable iff (reset) // (R9)
    $rose(cmd_valid) && sent_sel == MCD_START_MASTER_TRANSFER |-> cmd_code == 11'h723)
    else $error("master transfer code wrong");

  AST_MISC_CODE: assert property (@(posedge clk) disable iff (reset) // (R10)
    $rose(cmd_valid) && sent_sel == MCD_UNLOCK_RETENTION |-> cmd_code == 11'h038)
    else $error("retention unlock code wrong");

  AST_VALID_HOLD: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code))
    else $error("command dropped before taken");

  AST_HB_REFUSED: assert property (@(posedge clk) disable iff (reset) // (R14)
    go && state == MCD_ST_IDLE && cur_sel == MCD_LOW_POWER_HEARTBEAT && !lp_active |=>
    refused && !cmd_valid)
    else $error("heartbeat sent outside low-power mode");

  AST_COUNT_STILL: assert property (@(posedge clk) disable iff (reset) // (R12)
    state == MCD_ST_SEND && cmd_ready && sent_inc == MCD_INC_NONE &&
    sent_sel != MCD_RESET_COMMAND_COUNTER && sent_sel != MCD_SOFT_RESTART |=>
    exp_count == $past(exp_count))
    else $error("counter mirror moved on a non-counting command");

endmodule

//--- verilog/mcd_pkg.sv
// Package of the monitor command code builder: command selections,
// fixed command codes, increment classes, register map and reset values.
// Assumes the device decodes eleven-bit codes as listed here.
package mcd_pkg;

  // Command selections that software writes into the command register
  typedef enum logic [5:0] {
    MCD_READ_STATUS_GROUP_D, MCD_READ_STATUS_GROUP_E, MCD_READ_ALL_AUX_AND_STATUS,
    MCD_WRITE_BALANCE_PWM_A, MCD_READ_BALANCE_PWM_A, MCD_WRITE_BALANCE_PWM_B,
    MCD_READ_BALANCE_PWM_B, MCD_LOW_POWER_MONITOR_DISABLE, MCD_LOW_POWER_MONITOR_ENABLE,
    MCD_LOW_POWER_HEARTBEAT, MCD_WRITE_LOW_POWER_CONFIG, MCD_READ_LOW_POWER_CONFIG,
    MCD_WRITE_LOW_POWER_CELL_THRESHOLD, MCD_READ_LOW_POWER_CELL_THRESHOLD,
    MCD_WRITE_LOW_POWER_PIN_THRESHOLD, MCD_READ_LOW_POWER_PIN_THRESHOLD,
    MCD_CLEAR_LOW_POWER_FLAGS, MCD_READ_LOW_POWER_FLAGS, MCD_START_CELL_CONVERSION,
    MCD_START_S_CONVERSION, MCD_START_AUX_CONVERSION, MCD_START_SECOND_AUX_CONVERSION,
    MCD_CLEAR_CELL_RESULTS, MCD_CLEAR_FILTERED_RESULTS, MCD_CLEAR_AUX_RESULTS,
    MCD_CLEAR_S_CHANNEL_RESULTS, MCD_CLEAR_FAULT_FLAGS, MCD_CLEAR_OVER_UNDER_VOLTAGE,
    MCD_POLL_ANY_CONVERTER, MCD_POLL_CELL_CONVERTER, MCD_POLL_S_CONVERTER,
    MCD_POLL_AUX_CONVERTER, MCD_POLL_SECOND_AUX_CONVERTER, MCD_WRITE_MASTER_PORT_GROUP,
    MCD_READ_MASTER_PORT_GROUP, MCD_START_MASTER_TRANSFER, MCD_DISCHARGE_HALT,
    MCD_DISCHARGE_RESUME, MCD_READ_SERIAL_IDENTITY, MCD_RESET_COMMAND_COUNTER,
    MCD_SNAPSHOT_TAKE, MCD_SNAPSHOT_RELEASE, MCD_SOFT_RESTART, MCD_UNLOCK_RETENTION,
    MCD_WRITE_RETENTION
  } mcd_sel_t;

  // How the device's command counter reacts to a command
  typedef enum logic [1:0] {MCD_INC_NONE, MCD_INC_ALWAYS, MCD_INC_COND} mcd_inc_t;

  // Fixed command codes
  localparam logic [10:0] CC_RD_STAT_D = 11'h033;
  localparam logic [10:0] CC_RD_STAT_E = 11'h034;
  localparam logic [10:0] CC_RD_ALL_AS = 11'h035;
  localparam logic [10:0] CC_WR_PWM_A = 11'h020;
  localparam logic [10:0] CC_RD_PWM_A = 11'h022;
  localparam logic [10:0] CC_WR_PWM_B = 11'h021;
  localparam logic [10:0] CC_RD_PWM_B = 11'h023;
  localparam logic [10:0] CC_LP_DIS = 11'h040;
  localparam logic [10:0] CC_LP_EN = 11'h041;
  localparam logic [10:0] CC_LP_HB = 11'h043;
  localparam logic [10:0] CC_LP_WR_CFG = 11'h058;
  localparam logic [10:0] CC_LP_RD_CFG = 11'h059;
  localparam logic [10:0] CC_LP_WR_CELL = 11'h05A;
  localparam logic [10:0] CC_LP_RD_CELL = 11'h05B;
  localparam logic [10:0] CC_LP_WR_PIN = 11'h05C;
  localparam logic [10:0] CC_LP_RD_PIN = 11'h05D;
  localparam logic [10:0] CC_LP_CLR_FLAG = 11'h05E;
  localparam logic [10:0] CC_LP_RD_FLAG = 11'h05F;
  localparam logic [10:0] CC_CLR_CELL = 11'h711;
  localparam logic [10:0] CC_CLR_FILT = 11'h714;
  localparam logic [10:0] CC_CLR_AUX = 11'h712;
  localparam logic [10:0] CC_CLR_S = 11'h716;
  localparam logic [10:0] CC_CLR_FLAG = 11'h717;
  localparam logic [10:0] CC_CLR_OVUV = 11'h715;
  localparam logic [10:0] CC_POLL_ANY = 11'h718;
  localparam logic [10:0] CC_POLL_CELL = 11'h71C;
  localparam logic [10:0] CC_POLL_S = 11'h71D;
  localparam logic [10:0] CC_POLL_AUX = 11'h71E;
  localparam logic [10:0] CC_POLL_AUX2 = 11'h71F;
  localparam logic [10:0] CC_WR_MPORT = 11'h721;
  localparam logic [10:0] CC_RD_MPORT = 11'h722;
  localparam logic [10:0] CC_ST_MPORT = 11'h723;
  localparam logic [10:0] CC_DIS_HALT = 11'h028;
  localparam logic [10:0] CC_DIS_RESUME = 11'h029;
  localparam logic [10:0] CC_RD_SID = 11'h02C;
  localparam logic [10:0] CC_RST_CNT = 11'h02E;
  localparam logic [10:0] CC_SNAP = 11'h02D;
  localparam logic [10:0] CC_UNSNAP = 11'h02F;
  localparam logic [10:0] CC_SOFT_RST = 11'h027;
  localparam logic [10:0] CC_UNLOCK_RR = 11'h038;
  localparam logic [10:0] CC_WRITE_RR = 11'h039;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_GO = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;

  // Command register fields
  localparam int F_SEL = 0;
  localparam int F_CONTINUOUS_FLAG = 6;
  localparam int F_DCP = 7;
  localparam int F_FILTER_RESET_FLAG = 8;
  localparam int F_RED = 9;
  localparam int F_OW = 10;
  localparam int F_AOW = 12;
  localparam int F_PUP = 13;
  localparam int F_CH = 14;
  localparam int CMD_W = 19;

  // Status register fields
  localparam int F_BUSY = 0;
  localparam int F_REFUSED = 1;
  localparam int F_LP_ACTIVE = 2;
  localparam int F_LAST = 4;

  // Values after reset
  localparam logic [CMD_W-1:0] CMD_RESET = 19'h00000;
  localparam logic [10:0] CODE_RESET = 11'h000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

endpackage
